// >>> verilog/b1hr_regs.sv
// bridge type 1 header bytes 0Eh-1Dh: registers, forwarding, I/O window and tenure timer
//
// What this block does
// - header kind byte reads 01h, read-only
// - bridge layout covers bytes 10h to 3Fh only
// - self-test byte reads 00h, writes ignored
// - first window register reads zero, read-only
// - second window register reads zero, read-only
// - upstream bus number, read/write, resets 00h
// - downstream bus number, read/write, resets zero
// - highest bus number, read/write, resets zero
// - forward when target bus lies behind bridge
// - target equals downstream bus: forward as type 0
// - deeper bus behind bridge: forward as type 1
// - tenure timer counts clocks from frame start
// - expired timer ends transaction once grant withdrawn
// - grant withdrawn when another master requests bus
// - I/O base low nibble 0001b, high nibble writable
// - I/O limit low nibble 0001b, low bits FFFh
// - base upper 16 bits from base-upper register
// - limit upper 16 bits from limit-upper register
`timescale 1ns/1ps
`include "b1hr_defs.svh"

module b1hr_regs
    import b1hr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire b1hr_cfg_req_t cfg_in,
    output logic [31:0] cfg_rdata,
    output logic cfg_ack,
    input wire logic fwd_req,
    input wire logic [7:0] fwd_bus,
    output logic fwd_valid,
    output logic fwd_type0,
    output logic fwd_type1,
    input wire logic io_req,
    input wire logic [31:0] io_addr,
    input wire logic [15:0] io_base_upper,
    input wire logic [15:0] io_limit_upper,
    output logic io_valid,
    output logic io_hit,
    input wire logic frame_start,
    input wire logic xfer_done,
    input wire logic other_req,
    output logic grant_int,
    output logic tenure_expired,
    output logic end_xfer,
    output logic [7:0] up_bus_num,
    output logic [7:0] dn_bus_num,
    output logic [7:0] hi_bus_num
);

    b1hr_state_t st_reg;
    b1hr_state_t st_next;
    logic [31:0] io_base_full;
    logic [31:0] io_limit_full;
    logic [5:0] cfg_dw;

    function automatic logic [7:0] b1hr_wr_byte(
        input logic [7:0] old_val,
        input logic [7:0] new_val,
        input logic en
    );
        b1hr_wr_byte = en ? new_val : old_val;
    endfunction : b1hr_wr_byte

    function automatic logic b1hr_dw_is(input logic [5:0] dw, input logic [7:0] ofs);
        b1hr_dw_is = (dw == ofs[7:2]);
    endfunction : b1hr_dw_is

    assign cfg_dw = cfg_in.addr[7:2];
    // composed window edges; low twelve bits are implied, never stored
    assign io_base_full = {io_base_upper, st_reg.io_base_nib,
                           `B1HR_IO_BASE_FILL};
    assign io_limit_full = {io_limit_upper, st_reg.io_lim_nib,
                            `B1HR_IO_LIMIT_FILL};

    always_comb begin
        logic wr_bus;
        logic wr_io;
        wr_bus = cfg_in.req && cfg_in.we && b1hr_dw_is(cfg_dw, `B1HR_OFS_UP_BUS);
        wr_io = cfg_in.req && cfg_in.we && b1hr_dw_is(cfg_dw, `B1HR_OFS_IO_LOW);
        st_next = st_reg;

        // config access: answer one cycle later, unowned bytes read zero
        st_next.ack = cfg_in.req;
        st_next.rdata = 32'h0000_0000;
        if (cfg_in.req && !cfg_in.we) begin
            if (b1hr_dw_is(cfg_dw, `B1HR_OFS_HDR_KIND)) begin
                st_next.rdata[23:16] = `B1HR_RST_HDR_KIND;
                st_next.rdata[31:24] = `B1HR_RST_SELF_TEST;
            end else if (b1hr_dw_is(cfg_dw, `B1HR_OFS_WIN0)) begin
                st_next.rdata = `B1HR_RST_WIN;
            end else if (b1hr_dw_is(cfg_dw, `B1HR_OFS_WIN1)) begin
                st_next.rdata = `B1HR_RST_WIN;
            end else if (b1hr_dw_is(cfg_dw, `B1HR_OFS_UP_BUS)) begin
                st_next.rdata = {st_reg.tenure, st_reg.hi_bus, st_reg.dn_bus, st_reg.up_bus};
            end else if (b1hr_dw_is(cfg_dw, `B1HR_OFS_IO_LOW)) begin
                st_next.rdata[15:0] = {st_reg.io_lim_nib, `B1HR_IO_DECODE_32,
                                       st_reg.io_base_nib, `B1HR_IO_DECODE_32};
            end else begin
                st_next.rdata = 32'h0000_0000;
            end
        end
        // writes to the read-only bytes fall through and change nothing
        st_next.up_bus = b1hr_wr_byte(st_reg.up_bus, cfg_in.wdata[7:0],
                                      wr_bus && cfg_in.be[0]);
        st_next.dn_bus = b1hr_wr_byte(st_reg.dn_bus, cfg_in.wdata[15:8],
                                      wr_bus && cfg_in.be[1]);
        st_next.hi_bus = b1hr_wr_byte(st_reg.hi_bus, cfg_in.wdata[23:16],
                                      wr_bus && cfg_in.be[2]);
        st_next.tenure = b1hr_wr_byte(st_reg.tenure, cfg_in.wdata[31:24],
                                      wr_bus && cfg_in.be[3]);
        if (wr_io && cfg_in.be[0]) begin
            st_next.io_base_nib = cfg_in.wdata[`B1HR_IO_ADDR_MSB:`B1HR_IO_ADDR_LSB];
        end
        if (wr_io && cfg_in.be[1]) begin
            st_next.io_lim_nib =
                cfg_in.wdata[8 + `B1HR_IO_ADDR_MSB:8 + `B1HR_IO_ADDR_LSB];
        end

        // forwarding uses the bus numbers as they stood before any same-cycle write
        st_next.fwd_valid = fwd_req;
        st_next.fwd_type0 = fwd_req && (fwd_bus == st_reg.dn_bus);
        st_next.fwd_type1 = fwd_req && (fwd_bus > st_reg.dn_bus)
                            && (fwd_bus <= st_reg.hi_bus);

        st_next.io_valid = io_req;
        st_next.io_hit = io_req && (io_addr >= io_base_full)
                         && (io_addr <= io_limit_full);

        // internal grant follows the arbiter with one cycle of lag
        st_next.grant = !other_req;

        // tenure: count saturates so a long transfer cannot wrap back under the limit
        st_next.end_xfer = 1'b0;
        if (frame_start) begin
            st_next.active = 1'b1;
            st_next.count = 8'h00;
        end else if (st_reg.active && (xfer_done || st_reg.end_xfer)) begin
            st_next.active = 1'b0;
        end else if (st_reg.active) begin
            if (st_reg.count != `B1HR_TENURE_MAX) begin
                st_next.count = st_reg.count + 8'h01;
            end
            st_next.end_xfer = st_reg.expired && !st_reg.grant && !xfer_done;
        end
        st_next.expired = st_next.active && (st_next.count >= st_reg.tenure);
        if (st_next.end_xfer) begin
            st_next.active = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_reg <= '0;
            st_reg.up_bus <= `B1HR_RST_BUS;
            st_reg.dn_bus <= `B1HR_RST_BUS;
            st_reg.hi_bus <= `B1HR_RST_BUS;
            st_reg.tenure <= `B1HR_RST_TENURE;
            st_reg.io_base_nib <= `B1HR_RST_IO_NIB;
            st_reg.io_lim_nib <= `B1HR_RST_IO_NIB;
            st_reg.grant <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign cfg_rdata = st_reg.rdata;
    assign cfg_ack = st_reg.ack;
    assign fwd_valid = st_reg.fwd_valid;
    assign fwd_type0 = st_reg.fwd_type0;
    assign fwd_type1 = st_reg.fwd_type1;
    assign io_valid = st_reg.io_valid;
    assign io_hit = st_reg.io_hit;
    assign grant_int = st_reg.grant;
    assign tenure_expired = st_reg.expired;
    assign end_xfer = st_reg.end_xfer;
    assign up_bus_num = st_reg.up_bus;
    assign dn_bus_num = st_reg.dn_bus;
    assign hi_bus_num = st_reg.hi_bus;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_rd(logic [7:0] ofs);
        cfg_in.req && !cfg_in.we && (cfg_in.addr[7:2] == ofs[7:2]);
    endsequence

    property p_hdr_kind;
        s_rd(`B1HR_OFS_HDR_KIND) |=> cfg_ack && (cfg_rdata[23:16] == 8'h01);
    endproperty
    a_hdr_kind: assert property (p_hdr_kind) else $error("header kind not 01h");

    property p_self_test;
        s_rd(`B1HR_OFS_SELF_TEST) |=> cfg_rdata[31:24] == 8'h00;
    endproperty
    a_self_test: assert property (p_self_test) else $error("self-test byte not 00h");

    property p_win0;
        s_rd(`B1HR_OFS_WIN0) |=> cfg_ack && (cfg_rdata == 32'h0000_0000);
    endproperty
    a_win0: assert property (p_win0) else $error("window 0 not zero");

    property p_win1;
        s_rd(`B1HR_OFS_WIN1) |=> cfg_rdata == 32'h0000_0000;
    endproperty
    a_win1: assert property (p_win1) else $error("window 1 not zero");

    property p_up_bus_wr;
        cfg_in.req && cfg_in.we && (cfg_dw == 6'h06) && cfg_in.be[0]
            |=> up_bus_num == $past(cfg_in.wdata[7:0]);
    endproperty
    a_up_bus_wr: assert property (p_up_bus_wr) else $error("upstream bus write lost");

    property p_type0;
        fwd_req && (fwd_bus == dn_bus_num) |=> fwd_valid && fwd_type0 && !fwd_type1;
    endproperty
    a_type0: assert property (p_type0) else $error("downstream bus not type 0");

    property p_type1;
        fwd_req && (fwd_bus > dn_bus_num) && (fwd_bus <= hi_bus_num)
            |=> fwd_type1 && !fwd_type0;
    endproperty
    a_type1: assert property (p_type1) else $error("deeper bus not type 1");

    property p_no_fwd;
        fwd_req && ((fwd_bus < dn_bus_num) || (fwd_bus > hi_bus_num))
            |=> fwd_valid && !fwd_type0 && !fwd_type1;
    endproperty
    a_no_fwd: assert property (p_no_fwd) else $error("bus outside range forwarded");

    property p_frame_zero;
        frame_start |=> st_reg.active && (st_reg.count == 8'h00);
    endproperty
    a_frame_zero: assert property (p_frame_zero) else $error("timer not cleared");

    property p_end_cause;
        end_xfer |-> $past(tenure_expired) && !$past(grant_int);
    endproperty
    a_end_cause: assert property (p_end_cause) else $error("end without expiry");

    property p_grant_drop;
        other_req |=> !grant_int;
    endproperty
    a_grant_drop: assert property (p_grant_drop) else $error("grant kept");

    property p_io_nibbles;
        s_rd(`B1HR_OFS_IO_LOW) |=> (cfg_rdata[3:0] == 4'h1) && (cfg_rdata[11:8] == 4'h1);
    endproperty
    a_io_nibbles: assert property (p_io_nibbles) else $error("I/O nibble wrong");

    property p_io_hit;
        io_req |=> io_valid && (io_hit == (($past(io_addr) >= $past(io_base_full))
                                && ($past(io_addr) <= $past(io_limit_full))));
    endproperty
    a_io_hit: assert property (p_io_hit) else $error("I/O window decode wrong");

    property p_limit_fill;
        io_limit_full[11:0] == 12'hFFF && io_base_full[11:0] == 12'h000
            && io_limit_full[31:16] == io_limit_upper && io_base_full[31:16] == io_base_upper;
    endproperty
    a_limit_fill: assert property (p_limit_fill) else $error("I/O edge fill wrong");

    sequence s_wr(logic [7:0] ofs, int lane);
        cfg_in.req && cfg_in.we && (cfg_in.addr[7:2] == ofs[7:2]) && cfg_in.be[lane];
    endsequence

    // timer steps: running with no restart, finish or cut pending, then due to be cut
    sequence s_running;
        st_reg.active && !frame_start && !xfer_done && !end_xfer;
    endsequence

    sequence s_due;
        s_running ##0 (tenure_expired && !grant_int);
    endsequence

    property p_unowned_rd;
        cfg_in.req && !cfg_in.we && ((cfg_dw < 6'h03) || (cfg_dw > 6'h07))
            |=> cfg_ack && (cfg_rdata == 32'h0000_0000);
    endproperty
    a_unowned_rd: assert property (p_unowned_rd) else $error("unowned dword nonzero");

    property p_dn_bus_wr;
        s_wr(`B1HR_OFS_UP_BUS, 1) |=> dn_bus_num == $past(cfg_in.wdata[15:8]);
    endproperty
    a_dn_bus_wr: assert property (p_dn_bus_wr) else $error("downstream bus lost");

    property p_hi_bus_wr;
        s_wr(`B1HR_OFS_UP_BUS, 2) |=> hi_bus_num == $past(cfg_in.wdata[23:16]);
    endproperty
    a_hi_bus_wr: assert property (p_hi_bus_wr) else $error("highest bus lost");

    property p_bus_hold;
        !(cfg_in.req && cfg_in.we && (cfg_dw == 6'h06))
            |=> $stable(up_bus_num) && $stable(dn_bus_num) && $stable(hi_bus_num);
    endproperty
    a_bus_hold: assert property (p_bus_hold) else $error("bus number drifted");

    property p_tenure_wr;
        s_wr(`B1HR_OFS_UP_BUS, 3) |=> st_reg.tenure == $past(cfg_in.wdata[31:24]);
    endproperty
    a_tenure_wr: assert property (p_tenure_wr) else $error("tenure write lost");

    property p_io_base_wr;
        s_wr(`B1HR_OFS_IO_LOW, 0) |=> st_reg.io_base_nib == $past(cfg_in.wdata[7:4]);
    endproperty
    a_io_base_wr: assert property (p_io_base_wr) else $error("I/O base lost");

    property p_io_lim_wr;
        s_wr(`B1HR_OFS_IO_LOW, 1) |=> st_reg.io_lim_nib == $past(cfg_in.wdata[15:12]);
    endproperty
    a_io_lim_wr: assert property (p_io_lim_wr) else $error("I/O limit lost");

    property p_count_step;
        s_running ##0 (st_reg.count != `B1HR_TENURE_MAX)
            |=> st_reg.count == $past(st_reg.count) + 8'h01;
    endproperty
    a_count_step: assert property (p_count_step) else $error("timer stalled");

    property p_count_sat;
        s_running ##0 (st_reg.count == `B1HR_TENURE_MAX)
            |=> st_reg.count == `B1HR_TENURE_MAX;
    endproperty
    a_count_sat: assert property (p_count_sat) else $error("timer wrapped");

    property p_end_due;
        s_due |=> end_xfer;
    endproperty
    a_end_due: assert property (p_end_due) else $error("late end");

    property p_end_once;
        end_xfer |=> !end_xfer;
    endproperty
    a_end_once: assert property (p_end_once) else $error("end held");

    property p_done_stop;
        st_reg.active && xfer_done && !frame_start |=> !st_reg.active && !tenure_expired;
    endproperty
    a_done_stop: assert property (p_done_stop) else $error("timer kept running");

    property p_grant_back;
        !other_req |=> grant_int;
    endproperty
    a_grant_back: assert property (p_grant_back) else $error("grant not back");

    property p_fwd_idle;
        !fwd_req |=> !fwd_valid && !fwd_type0 && !fwd_type1;
    endproperty
    a_fwd_idle: assert property (p_fwd_idle) else $error("stray forward");

    property p_io_idle;
        !io_req |=> !io_valid && !io_hit;
    endproperty
    a_io_idle: assert property (p_io_idle) else $error("stray I/O answer");

endmodule : b1hr_regs

// >>> verilog/b1hr_defs.svh
// offsets, field positions, reset values and fixed codes of the bridge header registers
`ifndef B1HR_DEFS_SVH
`define B1HR_DEFS_SVH

`define B1HR_OFS_HDR_KIND 8'h0E
`define B1HR_OFS_SELF_TEST 8'h0F
`define B1HR_OFS_WIN0 8'h10
`define B1HR_OFS_WIN1 8'h14
`define B1HR_OFS_UP_BUS 8'h18
`define B1HR_OFS_DN_BUS 8'h19
`define B1HR_OFS_HI_BUS 8'h1A
`define B1HR_OFS_TENURE 8'h1B
`define B1HR_OFS_IO_LOW 8'h1C
`define B1HR_OFS_IO_HIGH 8'h1D
`define B1HR_LAYOUT_FIRST 8'h10
`define B1HR_LAYOUT_LAST 8'h3F

`define B1HR_RST_HDR_KIND 8'h01
`define B1HR_RST_SELF_TEST 8'h00
`define B1HR_RST_WIN 32'h0000_0000
`define B1HR_RST_BUS 8'h00
`define B1HR_RST_TENURE 8'h00
`define B1HR_RST_IO_NIB 4'h0

`define B1HR_IO_DECODE_32 4'h1
`define B1HR_IO_ADDR_MSB 7
`define B1HR_IO_ADDR_LSB 4
`define B1HR_IO_BASE_FILL 12'h000
`define B1HR_IO_LIMIT_FILL 12'hFFF
`define B1HR_TENURE_MAX 8'hFF

`endif

// >>> verilog/b1hr_pkg.sv
// types shared by the bridge header register bank
package b1hr_pkg;

    typedef struct packed {
        logic req;
        logic we;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } b1hr_cfg_req_t;

    typedef struct packed {
        logic [7:0] up_bus;
        logic [7:0] dn_bus;
        logic [7:0] hi_bus;
        logic [7:0] tenure;
        logic [3:0] io_base_nib;
        logic [3:0] io_lim_nib;
        logic [31:0] rdata;
        logic ack;
        logic fwd_valid;
        logic fwd_type0;
        logic fwd_type1;
        logic io_valid;
        logic io_hit;
        logic active;
        logic [7:0] count;
        logic expired;
        logic grant;
        logic end_xfer;
    } b1hr_state_t;

endpackage : b1hr_pkg

// >>> dv/b1hr_host.sv
// host model that issues single configuration accesses to the header bank
`timescale 1ns/1ps

module b1hr_host
    import b1hr_pkg::*;
(
    input wire logic sys_clk,
    output b1hr_cfg_req_t cfg_out,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_ack
);
    initial begin
        cfg_out = '0;
    end

    // one request cycle only, since every cycle with req high counts as a new access
    task automatic access(input logic we, input logic [7:0] a, input logic [3:0] be,
                          input logic [31:0] wd, output logic [31:0] rd, output logic ok);
        rd = '0;
        ok = 1'b0;
        @(posedge sys_clk);
        #1;
        cfg_out = '{req: 1'b1, we: we, addr: a, be: be, wdata: wd};
        @(posedge sys_clk);
        #1;
        // released address and data lines flip so a stale value is never mistaken for a live one
        cfg_out = '{req: 1'b0, we: we, addr: ~a, be: be, wdata: ~wd};
        for (int i = 0; i < 4 && !ok; i++) begin
            if (cfg_ack === 1'b1) begin
                rd = cfg_rdata;
                ok = 1'b1;
            end else begin
                @(posedge sys_clk);
                #1;
            end
        end
    endtask : access
endmodule : b1hr_host

// >>> dv/b1hr_regs_tb_top.sv
// self-checking bench for the bridge header register bank
`timescale 1ns/1ps
`define CHK(g, e) check_val(g, e)

module b1hr_regs_tb_top
    import b1hr_pkg::*;
;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    b1hr_cfg_req_t cfg_in;
    logic cfg_ack, fwd_req, fwd_valid, fwd_type0, fwd_type1, io_req, io_valid, io_hit;
    logic frame_start, xfer_done, other_req, grant_int, tenure_expired, end_xfer;
    logic [7:0] fwd_bus, up_bus_num, dn_bus_num, hi_bus_num;
    logic [15:0] io_base_upper, io_limit_upper;
    logic [31:0] cfg_rdata, io_addr;
    logic [31:0] seed = 32'h0000_212e;
    logic [7:0] ofs [6] = '{8'h0C, 8'h10, 8'h14, 8'h20, 8'h18, 8'h1C};
    logic [31:0] exp_rd [6] = '{32'h0001_0000, 0, 0, 0, 0, 32'h0000_0101};
    int err_count = 0;
    int checked = 0;

    always #10 sys_clk = ~sys_clk;

    b1hr_host i_b1hr_host (.sys_clk(sys_clk), .cfg_out(cfg_in), .cfg_rdata(cfg_rdata),
        .cfg_ack(cfg_ack));
    b1hr_regs i_b1hr_regs (.sys_clk(sys_clk), .sys_rst(sys_rst), .cfg_in(cfg_in),
        .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .fwd_req(fwd_req), .fwd_bus(fwd_bus),
        .fwd_valid(fwd_valid), .fwd_type0(fwd_type0), .fwd_type1(fwd_type1),
        .io_req(io_req), .io_addr(io_addr), .io_base_upper(io_base_upper),
        .io_limit_upper(io_limit_upper), .io_valid(io_valid), .io_hit(io_hit),
        .frame_start(frame_start), .xfer_done(xfer_done), .other_req(other_req),
        .grant_int(grant_int), .tenure_expired(tenure_expired), .end_xfer(end_xfer),
        .up_bus_num(up_bus_num), .dn_bus_num(dn_bus_num), .hi_bus_num(hi_bus_num));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [31:0] mbe(logic [31:0] o, logic [31:0] n, logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            if (be[i]) o[8*i +: 8] = n[8*i +: 8];
        end
        return o;
    endfunction : mbe

    function automatic logic [2:0] exp_fwd(logic [7:0] b, logic [7:0] dn, logic [7:0] top);
        return {1'b1, b == dn, (b > dn) && (b <= top)};
    endfunction : exp_fwd

    function automatic logic [1:0] exp_io(logic [31:0] x, logic [31:0] lo, logic [31:0] hi);
        return {1'b1, (x >= lo) && (x <= hi)};
    endfunction : exp_io

    task automatic check_val(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check_val

    task automatic stop_test();
        $display("mismatches=%0d comparisons=%0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    task automatic cfg(input logic we, input logic [7:0] a, input logic [3:0] be,
                       input logic [31:0] wd, output logic [31:0] rd);
        logic ok;
        i_b1hr_host.access(we, a, be, wd, rd, ok);
        if (!ok) begin
            err_count++;
            stop_test();
        end
    endtask : cfg

    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask : tick

    initial begin
        logic [31:0] rd, w, r18, r1c, a, lo, hi;
        logic [2:0] ex;
        logic [15:0] bu;
        logic [3:0] be;
        logic seen;
        int n;
        {fwd_req, io_req, frame_start, xfer_done, other_req, fwd_bus, io_addr} = '0;
        {io_base_upper, io_limit_upper} = '0;
        repeat (16) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        // second pass hammers the read-only and unowned dwords with ones first
        for (int p = 0; p < 2; p++) begin
            foreach (ofs[i]) begin
                if (p == 1 && i < 4) cfg(1'b1, ofs[i], 4'hF, 32'hFFFF_FFFF, rd);
                cfg(1'b0, ofs[i], 4'hF, '0, rd);
                `CHK(rd, exp_rd[i]);
            end
        end
        r18 = '0;
        r1c = 32'h0000_0101;
        repeat (8) begin
            w = rnd();
            be = w[11:8];
            cfg(1'b1, 8'h18, be, w, rd);
            r18 = mbe(r18, w, be);
            cfg(1'b0, 8'h18, 4'hF, '0, rd);
            `CHK(rd, r18);
            `CHK({hi_bus_num, dn_bus_num, up_bus_num}, r18[23:0]);
            cfg(1'b1, 8'h1C, ~be, ~w, rd);
            r1c = mbe(r1c, ~w & 32'h0000_F0F0, ~be & 4'h3) | 32'h0000_0101;
            cfg(1'b0, 8'h1C, 4'hF, '0, rd);
            `CHK(rd, r1c);
        end
        cfg(1'b1, 8'h18, 4'hF, 32'h0009_0501, rd);
        fwd_req = 1'b1;
        for (int k = 0; k < 20; k++) begin
            w = rnd();
            fwd_bus = (k < 12) ? k[7:0] : w[7:0];
            tick();
            ex = exp_fwd(fwd_bus, 8'h05, 8'h09);
            `CHK({fwd_valid, fwd_type0, fwd_type1}, ex);
        end
        fwd_req = 1'b0;
        cfg(1'b1, 8'h1C, 4'h3, 32'h0000_5030, rd);
        w = rnd();
        bu = {2'b00, w[13:0]};
        io_base_upper = bu;
        io_limit_upper = bu + 16'h0001;
        lo = {bu, 4'h3, 12'h000};
        hi = {bu + 16'h0001, 4'h5, 12'hFFF};
        io_req = 1'b1;
        for (int k = 0; k < 16; k++) begin
            w = rnd();
            a = {bu + {14'h0000, w[17:16]}, w[15:0]};
            io_addr = (k == 0) ? lo - 32'h0000_0001 : (k == 1) ? lo : (k == 2) ? hi :
                      (k == 3) ? hi + 32'h0000_0001 : a;
            tick();
            ex = {1'b0, exp_io(io_addr, lo, hi)};
            `CHK({io_valid, io_hit}, ex[1:0]);
        end
        io_req = 1'b0;
        other_req = 1'b1;
        tick();
        `CHK(grant_int, 1'b0);
        for (int t = 0; t < 8; t += 3) begin
            cfg(1'b1, 8'h18, 4'h8, {t[7:0], 24'h00_0000}, rd);
            frame_start = 1'b1;
            tick();
            frame_start = 1'b0;
            n = 0;
            while (end_xfer !== 1'b1 && n < 20) begin
                tick();
                n++;
            end
            `CHK(n, t + 1);
            if (n >= 20) stop_test();
            tick();
            `CHK(end_xfer, 1'b0);
        end
        other_req = 1'b0;
        tick();
        `CHK(grant_int, 1'b1);
        frame_start = 1'b1;
        tick();
        frame_start = 1'b0;
        // long enough to reach the count ceiling: a wrap would show as extra idle cycles
        seen = 1'b0;
        n = 0;
        repeat (300) begin
            tick();
            seen |= end_xfer;
            if (tenure_expired !== 1'b1) n++;
        end
        `CHK(seen, 1'b0);
        `CHK(n, 5);
        `CHK(tenure_expired, 1'b1);
        xfer_done = 1'b1;
        tick();
        xfer_done = 1'b0;
        tick();
        `CHK(tenure_expired, 1'b0);
        sys_rst = 1'b1;
        repeat (2) tick();
        sys_rst = 1'b0;
        cfg(1'b0, 8'h18, 4'hF, '0, rd);
        `CHK(rd, 32'h0000_0000);
        stop_test();
    end
endmodule : b1hr_regs_tb_top
